// File: rtl/wdt_counter.sv
// watchdog oscillator cycle counter with prescaled time-out compare
`timescale 1ns/1ps
module wdt_counter
    import wdt_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       clear_i,
    input  wire logic       tick_i,
    input  wire logic [3:0] sel_i,
    output logic            timeout_o
);
    logic [W-1:0] cnt;
    wire  [3:0]   sel_c;
    wire  [W-1:0] last;
    wire          hit;

    assign sel_c = (sel_i > PS_LAST) ? PS_LAST : sel_i; // RULE26
    assign last  = W'((BASE_CYCLES << sel_c) - 1); // RULE11
    // a shorter period with cnt already past it fires on the next tick
    assign hit   = (cnt >= last);
    assign timeout_o = tick_i & hit;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i | clear_i) begin
            cnt <= '0; // RULE25
        end else if (tick_i) begin
            cnt <= hit ? '0 : W'(cnt + 1'b1); // RULE24
        end
    end

endmodule : wdt_counter

// File: rtl/wdt_pkg.sv
// package of constants, register map and mode codes for the watchdog block
// ==========================================================================
// Summary of operation
// RULE1 - reset enable reads one while watchdog reset flag is set; clear flag first
// RULE2 - change enable clears itself four cpu clock cycles after being written one
// RULE3 - clearing reset enable or changing prescaler needs change enable set
// RULE4 - time-out in an interrupt mode sets the interrupt flag, control bit 7
// RULE5 - interrupt flag clears on vector execution or on writing one to it
// RULE6 - interrupt requested only with global enable, interrupt enable and flag set
// RULE7 - mode from fuse, reset enable, interrupt enable; fuse forces reset mode
// RULE8 - combined mode: first time-out sets flag; vector clears enable and flag
// RULE9 - combined mode: time-out with flag still pending applies a system reset
// RULE10 - prescaler select msb at control bit 5, low bits at 2 down to 0
// RULE11 - time-out after 2048 oscillator cycles doubled per code step, up to 1048576
// RULE12 - jtag reset flag, status bit 4, set on jtag reset, cleared by zero write
// RULE13 - watchdog reset flag, status bit 3, set on watchdog reset
// RULE14 - brown-out reset flag, status bit 2, set on brown-out reset
// RULE15 - pin reset flag, status bit 1, set on external pin reset
// RULE16 - power-on flag, status bit 0, set on power-on, cleared only by zero write
// RULE17 - software should restart the counter before changing the prescaler
// RULE18 - init software should clear watchdog reset flag and reset enable
// RULE19 - software should read then clear the status register early after start-up
// RULE20 - software re-arms interrupt enable after each interrupt, outside the handler
// RULE21 - write change enable and reset enable ones, then settings within four cycles
// RULE22 - programmed fuse locks reset enable at one and interrupt enable at zero
// RULE23 - time-out in a reset mode emits a one-cycle system reset pulse
// RULE24 - counter advances on a separate 128kHz oscillator, independent of system clock
// RULE25 - counter clears on restart instruction and while the watchdog is stopped
// RULE26 - prescaler codes 1010 to 1111 are reserved, undefined time-out
package wdt_pkg;

    // ======================================================================
    // register map
    localparam logic [7:0] CTRL_OFF     = 8'h60;
    localparam logic [7:0] STAT_OFF     = 8'h64;
    localparam logic [7:0] AUX_OFF      = 8'h68;

    // ======================================================================
    // control fields
    localparam int         IRQ_FLAG_BIT = 7;
    localparam int         IRQ_EN_BIT   = 6;
    localparam int         PS_MSB_BIT   = 5;
    localparam int         CE_BIT       = 4;
    localparam int         RST_EN_BIT   = 3;
    localparam int         PS_LO_MSB    = 2;
    localparam int         GIE_BIT      = 0;

    // ======================================================================
    // status fields
    localparam int         JTAG_BIT     = 4;
    localparam int         WDT_BIT      = 3;
    localparam int         BOD_BIT      = 2;
    localparam int         PIN_BIT      = 1;
    localparam int         POR_BIT      = 0;
    localparam int         STAT_W       = 5;

    // ======================================================================
    // reset values
    localparam logic [3:0] PS_RST       = 4'h0;
    localparam logic [STAT_W-1:0] STAT_RST = 5'h01;
    localparam logic [2:0] CE_HOLD      = 3'h4;

    // ======================================================================
    // timing
    localparam int         OSC_FREQ_HZ  = 128000;
    localparam int         CLK_FREQ_HZ  = 20000000;
    localparam int         BASE_CYCLES  = 2048;
    localparam logic [3:0] PS_LAST      = 4'h9;
    localparam int         CNT_W        = 20;

    // ======================================================================
    // operating modes
    typedef enum logic [3:0] {
        WM_STOP = 4'b0001,
        WM_IRQ  = 4'b0010,
        WM_RST  = 4'b0100,
        WM_BOTH = 4'b1000
    } wdt_mode_e;

endpackage : wdt_pkg

// File: rtl/wdt_sync.sv
// three-stage synchroniser and rising-edge detector for the watchdog oscillator
`timescale 1ns/1ps
module wdt_sync (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic async_i,
    output logic      rise_o
);
    logic s1;
    logic s2;
    logic s3;
    logic lvl;

    always_ff @(posedge ref_clk_i) begin
        s1 <= async_i;
        s2 <= s1;
        s3 <= s2;
    end

    // level only moves once the last two stages agree
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            lvl    <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            if (s2 == s3) begin
                lvl <= s3;
            end
            rise_o <= (s2 == s3) & s3 & ~lvl;
        end
    end

endmodule : wdt_sync

// File: rtl/wdt_top.sv
// watchdog control, reset-cause flags and avalon-mm register slave
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module wdt_top
    import wdt_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              wdt_osc_i,
    input  wire logic              always_on_fuse_i,
    input  wire logic              vector_ack_i,
    input  wire logic              restart_i,
    input  wire logic              jtag_rst_i,
    input  wire logic              brownout_rst_i,
    input  wire logic              pin_rst_i,
    output logic                   wdt_irq_o,
    output logic                   sys_reset_o
);

    // ======================================================================
    // state
    logic              fuse;
    logic              irq_flag;
    logic              irq_en;
    logic              rst_en;
    logic              ce;
    logic [2:0]        ce_cnt;
    logic [3:0]        ps;
    logic [STAT_W-1:0] stat;
    logic              gie;
    wdt_mode_e         mode;

    // ======================================================================
    // bus decode
    wire               req;
    wire               wr_acc;
    wire               rd_take;
    wire               sel_ctrl;
    wire               sel_stat;
    wire               sel_aux;
    wire               ctrl_we;
    wire               stat_we;
    wire               aux_we;
    wire [7:0]         wd;
    wire [7:0]         ctrl_rd;
    wire [7:0]         stat_rd;
    wire [7:0]         aux_rd;
    wire [7:0]         rd_mux;

    assign req      = avs_read_i | avs_write_i;
    assign wr_acc   = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
    assign rd_take  = avs_read_i & avs_waitrequest_o;
    assign sel_ctrl = (avs_address_i == ADDR_W'(CTRL_OFF));
    assign sel_stat = (avs_address_i == ADDR_W'(STAT_OFF));
    assign sel_aux  = (avs_address_i == ADDR_W'(AUX_OFF));
    assign ctrl_we  = wr_acc & sel_ctrl;
    assign stat_we  = wr_acc & sel_stat;
    assign aux_we   = wr_acc & sel_aux;
    assign wd       = avs_writedata_i[7:0];

    // ======================================================================
    // effective mode bits
    wire               watchdog_reset_flag;
    wire               wde_eff;
    wire               timeout_irq_enable_eff;
    wire               wd_ce;
    wire               wd_wde;
    wire [3:0]         wd_ps;

    assign watchdog_reset_flag     = stat[WDT_BIT];
    assign wde_eff  = rst_en | watchdog_reset_flag | fuse; // RULE1
    assign timeout_irq_enable_eff = irq_en & ~fuse; // RULE22
    assign wd_ce    = wd[CE_BIT];
    assign wd_wde   = wd[RST_EN_BIT];
    assign wd_ps    = {wd[PS_MSB_BIT], wd[PS_LO_MSB:0]};

    assign ctrl_rd  = {irq_flag, timeout_irq_enable_eff, ps[3], ce,
                       wde_eff, ps[2:0]}; // RULE10
    assign stat_rd  = {{(8-STAT_W){1'b0}}, stat};
    assign aux_rd   = {7'h00, gie};
    assign rd_mux   = sel_ctrl ? ctrl_rd :
                      sel_stat ? stat_rd :
                      sel_aux  ? aux_rd  : 8'h00;

    // ======================================================================
    // mode select
    always_comb begin
        if (fuse) begin
            mode = WM_RST; // RULE7
        end else begin
            unique case ({wde_eff, timeout_irq_enable_eff})
                2'b00: mode = WM_STOP;
                2'b01: mode = WM_IRQ;
                2'b10: mode = WM_RST;
                2'b11: mode = WM_BOTH; // RULE7
            endcase
        end
    end

    // ======================================================================
    // counter and time-out action
    wire               tick;
    wire               timeout;
    wire               soft_rst;
    wire               cnt_clr;
    wire               set_flag;
    wire               fire_rst;
    wire               is_stop;
    wire               is_irq;
    wire               is_rst;
    wire               is_both;

    assign is_stop  = (mode == WM_STOP);
    assign is_irq   = (mode == WM_IRQ);
    assign is_rst   = (mode == WM_RST);
    assign is_both  = (mode == WM_BOTH);

    // any other reset cause, or our own pulse, reinitialises control
    assign soft_rst = jtag_rst_i | brownout_rst_i | pin_rst_i | sys_reset_o;
    assign cnt_clr  = restart_i | is_stop | soft_rst; // RULE25

    assign set_flag = timeout & (is_irq | (is_both & ~irq_flag)); // RULE4
    assign fire_rst = timeout & (is_rst | (is_both & irq_flag)); // RULE9

    wdt_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (wdt_osc_i),
        .rise_o    (tick)
    ); // RULE24

    wdt_counter #(
        .W (CNT_W)
    ) u_cnt (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .clear_i   (cnt_clr),
        .tick_i    (tick),
        .sel_i     (ps),
        .timeout_o (timeout)
    ); // RULE11

    // ======================================================================
    // next values of control
    wire               flag_clr;
    wire               next_irq_flag;
    wire               next_irq_en;
    wire               next_rst_en;
    wire [3:0]         next_ps;
    wire               ce_load;
    wire               ce_end;

    assign flag_clr      = vector_ack_i |
                           (ctrl_we & wd[IRQ_FLAG_BIT]); // RULE5
    // a time-out in the clearing cycle still sets the flag
    assign next_irq_flag = set_flag | (irq_flag & ~flag_clr);

    assign next_irq_en   = fuse ? 1'b0 :
                           ctrl_we ? wd[IRQ_EN_BIT] :
                           (vector_ack_i & wde_eff) ? 1'b0 :
                           irq_en; // RULE8

    // setting is free; clearing needs the window and no pending watchdog_reset_flag
    assign next_rst_en   = (ctrl_we & wd_wde) ? 1'b1 :
                           (ctrl_we & ce & ~watchdog_reset_flag) ? 1'b0 :
                           rst_en; // RULE3

    assign next_ps       = (ctrl_we & ce) ? wd_ps : ps; // RULE3

    assign ce_load       = ctrl_we & wd_ce; // RULE21
    assign ce_end        = (ctrl_we & ~wd_ce) | (ce_cnt == 3'h0);

    // ======================================================================
    // bus handshake and read data
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata_o <= {24'h00_0000, rd_mux};
        end
    end

    // ======================================================================
    // fuse capture
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            fuse <= always_on_fuse_i;
        end
    end

    // ======================================================================
    // control register
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i | soft_rst) begin
            irq_flag <= 1'b0;
            irq_en   <= 1'b0;
            rst_en   <= 1'b0;
            ps       <= PS_RST;
        end else begin
            irq_flag <= next_irq_flag;
            irq_en   <= next_irq_en;
            rst_en   <= next_rst_en;
            ps       <= next_ps; // RULE10
        end
    end

    // ======================================================================
    // change-enable window
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i | soft_rst) begin
            ce     <= 1'b0;
            ce_cnt <= 3'h0;
        end else if (ce_load) begin
            ce     <= 1'b1;
            ce_cnt <= CE_HOLD - 3'h1; // RULE2
        end else if (ce & ce_end) begin
            ce     <= 1'b0; // RULE2
        end else if (ce) begin
            ce_cnt <= ce_cnt - 3'h1;
        end
    end

    // ======================================================================
    // global interrupt gate
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i | soft_rst) begin
            gie <= 1'b0;
        end else if (aux_we) begin
            gie <= wd[GIE_BIT];
        end
    end

    // ======================================================================
    // reset-cause flags
    wire [STAT_W-1:0]  stat_set;

    assign stat_set[JTAG_BIT] = jtag_rst_i; // RULE12
    assign stat_set[WDT_BIT]  = fire_rst; // RULE13
    assign stat_set[BOD_BIT]  = brownout_rst_i; // RULE14
    assign stat_set[PIN_BIT]  = pin_rst_i; // RULE15
    assign stat_set[POR_BIT]  = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < STAT_W; gi++) begin : g_stat
            wire clr;
            assign clr = stat_we & ~wd[gi];
            // power-on sets por and clears the others; set beats clear
            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i) begin
                    stat[gi] <= STAT_RST[gi]; // RULE16
                end else begin
                    stat[gi] <= stat_set[gi] | (stat[gi] & ~clr);
                end
            end
        end
    endgenerate

    // ======================================================================
    // outputs
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sys_reset_o <= 1'b0;
            wdt_irq_o   <= 1'b0;
        end else begin
            sys_reset_o <= fire_rst; // RULE23
            wdt_irq_o   <= irq_flag & timeout_irq_enable_eff & gie; // RULE6
        end
    end

endmodule : wdt_top

// File: sim/wdt_top_props.sv
// assertion checker for the watchdog block ports
`timescale 1ns/1ps
module wdt_top_props
    import wdt_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              ref_clk_i,
    input wire logic              sys_rst_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic              always_on_fuse_i,
    input wire logic              vector_ack_i,
    input wire logic              restart_i,
    input wire logic              wdt_irq_o,
    input wire logic              sys_reset_o
);
    // ==========
    // shadow state
    logic [2:0] since_wr;
    logic       fuse_q;
    logic       watchdog_reset_flag_sh;
    wire        wr_done  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    wire        ctrl_wr  = wr_done && avs_address_i == CTRL_OFF;
    wire        ctrl_rd  = avs_read_i && avs_waitrequest_o && avs_address_i == CTRL_OFF;
    wire        stat_clr = wr_done && avs_address_i == STAT_OFF && !avs_writedata_i[WDT_BIT];

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            since_wr <= 3'h7;
            fuse_q   <= always_on_fuse_i;
            watchdog_reset_flag_sh  <= 1'b0;
        end else begin
            since_wr <= ctrl_wr ? 3'h0 : (since_wr == 3'h7) ? 3'h7 : since_wr + 3'h1;
            watchdog_reset_flag_sh  <= sys_reset_o || (watchdog_reset_flag_sh && !stat_clr);
        end
    end

    // ==========
    // properties
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence answer_s;
        ##1 !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    sequence quiet_s;
        (!sys_reset_o) [*8];
    endsequence

    chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |-> answer_s)
        else $error("bus access not answered after one wait cycle");
    chk_reset_pulse: assert property (sys_reset_o |=> !sys_reset_o)
        else $error("system reset pulse longer than one cycle");
    chk_ce_expire: assert property (ctrl_rd && since_wr >= 3'h4 |=> !avs_readdata_o[CE_BIT])
        else $error("change enable still set long after write");
    chk_watchdog_reset_flag_forces: assert property (ctrl_rd && watchdog_reset_flag_sh |=> avs_readdata_o[RST_EN_BIT])
        else $error("reset enable reads zero with reset flag set");
    chk_fuse_lock: assert property (ctrl_rd && fuse_q |=> avs_readdata_o[RST_EN_BIT] && !avs_readdata_o[IRQ_EN_BIT])
        else $error("fuse does not lock the enables");
    chk_fuse_quiet: assert property (fuse_q |-> !wdt_irq_o)
        else $error("interrupt raised with fuse programmed");
    chk_vector_drop: assert property (vector_ack_i |-> ##2 !wdt_irq_o)
        else $error("interrupt still raised after vector");
    chk_restart_quiet: assert property (restart_i |-> ##3 quiet_s)
        else $error("time-out right after restart");
endmodule : wdt_top_props

bind wdt_top wdt_top_props #(.ADDR_W(ADDR_W)) wdt_top_props_i (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .always_on_fuse_i(always_on_fuse_i),
    .vector_ack_i(vector_ack_i), .restart_i(restart_i), .wdt_irq_o(wdt_irq_o), .sys_reset_o(sys_reset_o)
);

// File: sim/wdt_top_tb_top.sv
// self-checking testbench for the watchdog block
`timescale 1ns/1ps
module wdt_top_tb_top
    import wdt_pkg::*;
;
    localparam int OSC_DIV = 8;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        rd_s = 1'b0;
    logic        wr_s = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hf;
    logic [31:0] rdata;
    logic        wreq;
    logic        osc = 1'b0;
    logic        fuse = 1'b0;
    logic [4:0]  pls = 5'h00;
    logic        irq;
    logic        srst;
    logic [31:0] seed = 32'h2286bf6a;
    int          fail_count = 0;
    int          compares = 0;

    wdt_top wdt_top_i (
        .ref_clk_i(clk), .sys_rst_i(rst), .avs_address_i(addr), .avs_read_i(rd_s), .avs_write_i(wr_s),
        .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .wdt_osc_i(osc), .always_on_fuse_i(fuse), .vector_ack_i(pls[0]), .restart_i(pls[1]),
        .jtag_rst_i(pls[2]), .brownout_rst_i(pls[3]), .pin_rst_i(pls[4]), .wdt_irq_o(irq), .sys_reset_o(srst)
    );

    always #25 clk = ~clk;

    always begin
        repeat (OSC_DIV / 2) @(posedge clk);
        osc <= ~osc;
    end

    // ==========
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [7:0] ps_ctrl(input logic [3:0] p);
        return {2'b00, p[3], 2'b00, p[2:0]};
    endfunction : ps_ctrl

    // one when the wait matches the base count, allowing for sync and phase delay
    function automatic logic [7:0] in_time(input int n);
        return {7'h0, n >= (BASE_CYCLES - 1) * OSC_DIV && n <= BASE_CYCLES * OSC_DIV + 24};
    endfunction : in_time

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : cmp

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        seed = xs(seed);
        rd_s  <= !w;
        wr_s  <= w;
        addr  <= a;
        wdata <= {seed[31:8], d};
        @(posedge clk);
        while (wreq !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        q = rdata[7:0];
        if (n >= 100)
            cmp(8'h00, 8'h01, "bus never answered");
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        cmp(q, e, m);
    endtask : rd

    // event pulse: 0 vector, 1 restart, 2 jtag, 3 brown-out, 4 pin
    task automatic pulse(input int k);
        pls <= 5'h01 << k;
        @(posedge clk);
        pls <= 5'h00;
        @(posedge clk);
    endtask : pulse

    task automatic wait_out(input logic rst_kind, output int n);
        n = 0;
        while ((rst_kind ? srst : irq) !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_out

    task automatic probe(input logic e, input string m);
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp({7'h0, irq}, {7'h0, e}, m);
        @(posedge clk);
    endtask : probe

    task automatic do_reset(input logic f);
        rst  <= 1'b1;
        fuse <= f;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    task automatic close_out;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    initial begin
        #4500000;
        fail_count++;
        close_out();
    end

    // ==========
    // scenarios
    initial begin
        logic [7:0] e;
        logic [3:0] p;
        int         n;
        do_reset(1'b0);
        rd(CTRL_OFF, 8'h00, "ctrl reset");
        rd(STAT_OFF, 8'h01, "status reset");
        wr(8'h6c, 8'hff);
        rd(8'h6c, 8'h00, "unmapped read");
        be <= 4'he;
        wr(CTRL_OFF, 8'h08);
        be <= 4'hf;
        rd(CTRL_OFF, 8'h00, "byte lane off");
        e = 8'h01;
        for (int k = 2; k < 5; k++) begin
            pulse(k);
            e = e | (8'h01 << ((k == 2) ? JTAG_BIT : (k == 3) ? BOD_BIT : PIN_BIT));
            rd(STAT_OFF, e, "reset cause");
        end
        // expectation taken before the bus task advances the seed
        e = e & seed[7:0];
        wr(STAT_OFF, seed[7:0]);
        rd(STAT_OFF, e, "zero write");
        wr(STAT_OFF, 8'h00);
        wr(CTRL_OFF, 8'h08);
        wr(CTRL_OFF, 8'h00);
        rd(CTRL_OFF, 8'h08, "clear unprotected");
        wr(CTRL_OFF, 8'h18);
        rd(CTRL_OFF, 8'h18, "window open");
        repeat (4) @(posedge clk);
        rd(CTRL_OFF, 8'h08, "window closed");
        wr(CTRL_OFF, 8'h18);
        repeat (3) @(posedge clk);
        wr(CTRL_OFF, 8'h01);
        rd(CTRL_OFF, 8'h08, "late change");
        for (int i = 0; i < 7; i++) begin
            seed = xs(seed);
            p = (i == 0) ? 4'h9 : (i == 6) ? 4'h0 : 4'(seed % 10);
            pulse(1);
            wr(CTRL_OFF, 8'h18);
            wr(CTRL_OFF, ps_ctrl(p));
            rd(CTRL_OFF, ps_ctrl(p), "prescale");
        end
        wr(AUX_OFF, 8'h01);
        wr(CTRL_OFF, 8'h40);
        pulse(1);
        wait_out(1'b0, n);
        cmp(in_time(n), 8'h01, "irq count");
        rd(CTRL_OFF, 8'hc0, "irq flag");
        wr(AUX_OFF, 8'h00);
        probe(1'b0, "global off");
        wr(AUX_OFF, 8'h01);
        probe(1'b1, "all enabled");
        wr(CTRL_OFF, 8'hc0);
        rd(CTRL_OFF, 8'h40, "write one");
        wr(CTRL_OFF, 8'h48);
        pulse(1);
        wait_out(1'b0, n);
        cmp(in_time(n), 8'h01, "combined count");
        rd(CTRL_OFF, 8'hc8, "combined flag");
        pulse(0);
        rd(CTRL_OFF, 8'h08, "vector");
        wr(CTRL_OFF, 8'h48);
        pulse(1);
        wait_out(1'b0, n);
        rd(CTRL_OFF, 8'hc8, "rearmed");
        pulse(1);
        wait_out(1'b1, n);
        cmp(in_time(n), 8'h01, "unserviced");
        rd(STAT_OFF, 8'h08, "wd flag");
        rd(CTRL_OFF, 8'h08, "forced");
        wr(CTRL_OFF, 8'h18);
        wr(CTRL_OFF, 8'h00);
        rd(CTRL_OFF, 8'h08, "blocked");
        wr(STAT_OFF, 8'h00);
        wr(CTRL_OFF, 8'h18);
        wr(CTRL_OFF, 8'h00);
        rd(CTRL_OFF, 8'h00, "off");
        do_reset(1'b1);
        rd(CTRL_OFF, 8'h08, "fuse");
        rd(STAT_OFF, 8'h01, "power-on");
        wr(CTRL_OFF, 8'h40);
        wr(CTRL_OFF, 8'h18);
        wr(CTRL_OFF, 8'h00);
        rd(CTRL_OFF, 8'h08, "fuse lock");
        close_out();
    end
endmodule : wdt_top_tb_top
